// ---- testbench/au_arith_unit_properties.sv ----
module au_props (
	input wire       CLOCK,
	input wire       SRST,
	input wire [2:0] ADDR,
	input wire [7:0] WDATA,
	input wire       WR,
	input wire       RD,
	input wire [7:0] RDATA,
	input wire       BUSY
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (SRST);
	wire bad = BUSY && (WR || RD) && ADDR < 3'h6;
	wire stat = RD && ADDR == 3'h6;
	wire wr5 = WR && ADDR == 3'h5;
	reg  err_seen;
	// A status read clears the error only when no error access wins the same cycle.
	always @(posedge CLOCK) begin
		if (SRST)
			err_seen <= 1'b0;
		else if (bad)
			err_seen <= 1'b1;
		else if (stat)
			err_seen <= 1'b0;
	end
	sequence s_launch;
		$rose(BUSY);
	endsequence
	a_status_low: assert property (stat |=> RDATA[5:0] == 6'h00)
		else $error("status low bits not zero");
	a_busy_min: assert property (s_launch |-> BUSY[*8])
		else $error("calculation too short");
	a_busy_max: assert property (s_launch |-> ##[9:17] !BUSY)
		else $error("calculation too long");
	a_start_cause: assert property (s_launch |-> $past(wr5))
		else $error("start without data 5 write");
	a_err_set: assert property (stat && err_seen |=> RDATA[7])
		else $error("error flag missing");
	a_err_none: assert property (stat && !err_seen |=> !RDATA[7])
		else $error("error flag not clear");
	a_wr0_idle: assert property (WR && ADDR == 3'h0 && !BUSY |=> !BUSY)
		else $error("data 0 write started work");
	a_rdata_quiet: assert property (!RD |=> RDATA == 8'h00)
		else $error("read data outside slot");
endmodule

bind au_arith_unit au_props u_props (.CLOCK(CLOCK), .SRST(SRST), .ADDR(ADDR),
	.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .BUSY(BUSY));

// ---- testbench/tb_top.sv ----
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic       clock = 1'b0;
	logic       srst = 1'b1;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic [7:0] rdata;
	logic       busy;
	int         mismatches = 0;
	int         n_compared = 0;
	au_arith_unit u_dut (.CLOCK(clock), .SRST(srst), .ADDR(addr), .WDATA(wdata),
		.WR(wr), .RD(rd), .RDATA(rdata), .BUSY(busy));
	always #50 clock = ~clock;
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wreg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clock);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [2:0] a, input logic [7:0] e);
		@(posedge clock);
		rd <= 1'b1;
		addr <= a;
		@(posedge clock);
		rd <= 1'b0;
		@(negedge clock);
		chk(rdata, e);
	endtask
	// ==========================================================
	// One calculation: kind 0 is 32/16, 1 is 16/16, 2 is multiply.
	task automatic run(input int k, input logic [31:0] x, input logic [15:0] y,
		input logic e);
		logic [47:0] w;
		logic [47:0] r;
		logic [31:0] p;
		logic [23:0] sq;
		logic        ov;
		int          n;
		w = {y, x};
		r = w;
		p = x[15:0] * y;
		ov = (y == 16'h0000);
		sq = k == 0 ? 24'h543210 : k == 1 ? 24'h005410 : 24'h005140;
		if (k == 2) begin
			r = {y, p};
			ov = (p[31:16] != 16'h0000);
		end else if (k == 1 && !ov)
			r = {16'(x[15:0] % y), 16'h0000, 16'(x[15:0] / y)};
		else if (!ov)
			r = {16'(x % y), x / y};
		for (int i = 0; i < (k == 0 ? 6 : 4); i++) begin
			wreg(sq[4*i+:3], w[8*sq[4*i+:3]+:8]);
			// The gap read sits between writes only, so the busy count starts at launch.
			if (i < (k == 0 ? 5 : 3))
				rreg(3'h7, 8'h00);
		end
		if (e) begin
			rreg(3'h0, w[7:0]);
			wreg(3'h4, ~y[7:0]);
		end
		@(negedge clock);
		n = 0;
		while (busy === 1'b1 && n < 40) begin
			n++;
			@(negedge clock);
		end
		if (!e)
			chk(n[7:0], k == 0 ? 8'h11 : k == 1 ? 8'h09 : 8'h0B);
		rreg(3'h6, {e, ov, 6'h00});
		rreg(3'h6, {1'b0, ov, 6'h00});
		for (int i = 0; i < 6; i++)
			rreg(i[2:0], r[8*i+:8]);
		$display("test %0d done", k);
	endtask
	task automatic bad_seq;
		wreg(3'h0, 8'h01);
		wreg(3'h4, 8'h02);
		wreg(3'h2, 8'h03);
		wreg(3'h5, 8'h04);
		@(negedge clock);
		chk({7'h00, busy}, 8'h00);
		$display("broken sequence done");
	endtask
	task automatic end_of_test;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clock);
		srst <= 1'b0;
		run(2, 32'h00001234, 16'h5678, 1'b0);
		run(2, 32'h000000FF, 16'h0100, 1'b0);
		run(0, 32'h12345678, 16'h0FED, 1'b0);
		run(1, 32'h0000BEEF, 16'h0012, 1'b0);
		run(0, 32'h00000001, 16'h0000, 1'b0);
		run(2, 32'h00000003, 16'h0005, 1'b1);
		bad_seq();
		end_of_test();
	end
	// The whole run needs well under a thousand cycles.
	initial begin
		#200000;
		mismatches++;
		end_of_test();
	end
endmodule

// ---- verilog/au_arith_unit.v ----
`include "au_consts.vh"

module au_arith_unit (
	input  wire       CLOCK,
	input  wire       SRST,
	input  wire [2:0] ADDR,
	input  wire [7:0] WDATA,
	input  wire       WR,
	input  wire       RD,
	output reg  [7:0] RDATA,
	output reg        BUSY
);
	// ==========================================================
	// Sequence states
	localparam [2:0] SQ_IDLE = 3'h0;
	localparam [2:0] SQ_W0   = 3'h1;
	localparam [2:0] SQ_W01  = 3'h2;
	localparam [2:0] SQ_W012 = 3'h3;
	localparam [2:0] SQ_W0123 = 3'h4;
	localparam [2:0] SQ_W01234 = 3'h5;
	localparam [2:0] SQ_W04  = 3'h6;
	localparam [2:0] SQ_W041 = 3'h7;

	localparam [1:0] OP_DIV32 = 2'h0;
	localparam [1:0] OP_DIV16 = 2'h1;
	localparam [1:0] OP_MUL   = 2'h2;

	reg  [2:0]  seq_reg;
	reg  [2:0]  seq_next;
	reg  [1:0]  op_reg;
	reg  [4:0]  cnt_reg;
	reg         err_reg;
	reg         ovf_reg;
	reg         rd_stat_reg;
	reg         rd_data_reg;
	reg         w16_seen_reg;
	reg  [47:0] res_data;
	reg  [31:0] rem_full;
	reg         res_ovf;
	reg         start;
	reg  [1:0]  start_op;
	wire [7:0]  mem_rd;
	wire [47:0] opnd;
	wire        data_acc;
	wire        data_wr;
	wire        done;
	wire [31:0] dvd;
	wire [15:0] dvs;

	assign data_acc = (WR | RD) && (ADDR <= `AU_ADDR_DATA5);
	assign data_wr  = WR && (ADDR <= `AU_ADDR_DATA5) && !BUSY;
	assign done     = BUSY && (cnt_reg == 5'h01);
	assign dvs      = opnd[47:32];
	assign dvd      = (op_reg == OP_DIV32) ? opnd[31:0] : {16'h0000, opnd[15:0]};

	// ==========================================================
	// Data storage
	au_data_regs u_regs (
		.clk       (CLOCK),
		.wr_en     (data_wr),
		.wr_addr   (ADDR),
		.wr_data   (WDATA),
		.load_en   (done),
		.load_data (res_data),
		.rd_addr   (ADDR),
		.rd_data   (mem_rd),
		.all_data  (opnd)
	);

	// ==========================================================
	// Operand write sequence tracker
	always @* begin
		seq_next = seq_reg;
		start    = 1'b0;
		start_op = OP_DIV32;
		// [RULE9] Only data writes move it
		if (data_wr) begin
			// [RULE20] Mismatch drops sequence
			seq_next = SQ_IDLE;
			// [RULE7] [RULE10] [RULE11] [RULE12] order decode
			case (seq_reg)
				SQ_W0: begin
					if (ADDR == `AU_ADDR_DATA1) seq_next = SQ_W01;
					else if (ADDR == `AU_ADDR_DATA4) seq_next = SQ_W04;
				end
				SQ_W01: begin
					if (ADDR == `AU_ADDR_DATA2) seq_next = SQ_W012;
					else if (ADDR == `AU_ADDR_DATA4) seq_next = SQ_W01234;
				end
				SQ_W012: begin
					if (ADDR == `AU_ADDR_DATA3) seq_next = SQ_W0123;
				end
				SQ_W0123: begin
					if (ADDR == `AU_ADDR_DATA4) seq_next = SQ_W01234;
				end
				SQ_W01234: begin
					// [RULE8] Start on data 5
					if (ADDR == `AU_ADDR_DATA5) begin
						start    = 1'b1;
						start_op = w16_seen_reg ? OP_DIV16 : OP_DIV32;
					end
				end
				SQ_W04: begin
					if (ADDR == `AU_ADDR_DATA1) seq_next = SQ_W041;
				end
				SQ_W041: begin
					if (ADDR == `AU_ADDR_DATA5) begin
						start    = 1'b1;
						start_op = OP_MUL;
					end
				end
				default: begin
					seq_next = SQ_IDLE;
				end
			endcase
			// A write to data 0 always opens a fresh sequence.
			if (ADDR == `AU_ADDR_DATA0) seq_next = SQ_W0;
		end
	end

	// ==========================================================
	// Arithmetic
	always @* begin
		res_data = opnd;
		res_ovf  = 1'b0;
		rem_full = 32'h00000000;
		// [RULE1] [RULE18] multiply result
		if (op_reg == OP_MUL) begin
			res_data[31:0] = opnd[15:0] * opnd[47:32];
			// [RULE4] Product overflow
			res_ovf = (res_data[31:16] != 16'h0000);
		end else if (dvs == 16'h0000) begin
			// [RULE4] Zero divisor
			res_ovf = 1'b1;
		end else begin
			// [RULE16] [RULE17] quotient and remainder
			res_data[31:0]  = dvd / {16'h0000, dvs};
			res_data[47:32] = dvd[15:0] % dvs;
			if (op_reg == OP_DIV32) begin
				rem_full        = dvd % {16'h0000, dvs};
				res_data[47:32] = rem_full[15:0];
			end
		end
	end

	// ==========================================================
	// Control and status
	always @(posedge CLOCK) begin
		if (SRST) begin
			seq_reg      <= SQ_IDLE;
			op_reg       <= OP_DIV32;
			cnt_reg      <= 5'h00;
			BUSY         <= 1'b0;
			err_reg      <= 1'b0;
			ovf_reg      <= 1'b0;
			w16_seen_reg <= 1'b0;
			rd_stat_reg  <= 1'b0;
			rd_data_reg  <= 1'b0;
			RDATA        <= 8'h00;
		end else begin
			seq_reg     <= seq_next;
			rd_stat_reg <= RD && (ADDR == `AU_ADDR_STATUS);
			rd_data_reg <= RD && (ADDR <= `AU_ADDR_DATA5);
			if (data_wr && ADDR == `AU_ADDR_DATA0) w16_seen_reg <= 1'b1;
			if (data_wr && ADDR == `AU_ADDR_DATA2) w16_seen_reg <= 1'b0;
			if (start) begin
				op_reg <= start_op;
				BUSY   <= 1'b1;
				// [RULE13] Calculation length
				if (start_op == OP_DIV32) cnt_reg <= `AU_CYC_DIV32;
				else if (start_op == OP_DIV16) cnt_reg <= `AU_CYC_DIV16;
				else cnt_reg <= `AU_CYC_MUL;
			end else if (BUSY) begin
				cnt_reg <= cnt_reg - 5'h01;
				if (done) begin
					BUSY <= 1'b0;
					// [RULE5] Overflow refresh
					ovf_reg <= res_ovf;
				end
			end
			// [RULE2] [RULE14] access while busy; set wins over clear
			if (BUSY && data_acc) begin
				err_reg <= 1'b1;
			end else if (RD && ADDR == `AU_ADDR_STATUS) begin
				// [RULE3] [RULE15] Read clears
				err_reg <= 1'b0;
			end
			// [RULE19] Reads have no side effect on data
			if (rd_data_reg) begin
				RDATA <= 8'h00;
			end
			if (RD && ADDR == `AU_ADDR_STATUS) begin
				// [RULE6] Low bits zero
				RDATA <= {err_reg, ovf_reg, 6'h00};
			end else if (RD && ADDR <= `AU_ADDR_DATA5) begin
				RDATA <= opnd[ADDR*8 +: 8];
			end else begin
				RDATA <= 8'h00;
			end
		end
	end
endmodule

// ---- verilog/au_consts.vh ----
// Contract
// [RULE1] Unsigned 16x16 multiply and 32/16 divide are provided.
// [RULE2] Data register access during a calculation sets the error flag, bit 7.
// [RULE3] Reading the status register clears the error flag.
// [RULE4] Overflow flag, bit 6, set on product above FFFFH or zero divisor.
// [RULE5] Overflow flag is refreshed at the end of every calculation.
// [RULE6] Status bits five to zero read as zero.
// [RULE7] Software writes each operand low byte before high byte.
// [RULE8] A calculation starts only on a data 5 write closing a valid sequence.
// [RULE9] Gaps and other accesses between sequence writes do not break it.
// [RULE10] Writes 0,1,2,3,4,5 select 32/16 division.
// [RULE11] Writes 0,1,4,5 select 16/16 division.
// [RULE12] Writes 0,4,1,5 select 16x16 multiplication.
// [RULE13] Calculation takes 17, 9 or 11 clock periods.
// [RULE14] Software does not touch data registers during a calculation.
// [RULE15] Software checks status before reading results.
// [RULE16] 32/16 division leaves quotient in 0..3, remainder in 4..5.
// [RULE17] 16/16 division leaves quotient in 0..1, remainder in 4..5.
// [RULE18] Multiplication leaves the 32-bit product in 0..3, low byte first.
// [RULE19] Result reads may be separated by other activity without harm.
// [RULE20] A sequence state machine drops partial sequences on a mismatching write.
`ifndef AU_CONSTS_VH
`define AU_CONSTS_VH

// ==========================================================
// Register map
`define AU_ADDR_DATA0  3'h0
`define AU_ADDR_DATA1  3'h1
`define AU_ADDR_DATA2  3'h2
`define AU_ADDR_DATA3  3'h3
`define AU_ADDR_DATA4  3'h4
`define AU_ADDR_DATA5  3'h5
`define AU_ADDR_STATUS 3'h6

// ==========================================================
// Status fields
`define AU_ERR_BIT     7
`define AU_OVF_BIT     6
`define AU_STATUS_RST  8'h00

// ==========================================================
// Calculation lengths in clock periods
`define AU_CYC_DIV32   5'h11
`define AU_CYC_DIV16   5'h09
`define AU_CYC_MUL     5'h0B

`endif

// ---- verilog/au_data_regs.v ----
// ==========================================================
// Six byte data registers with a registered read port.
module au_data_regs (
	input  wire        clk,
	input  wire        wr_en,
	input  wire [2:0]  wr_addr,
	input  wire [7:0]  wr_data,
	input  wire        load_en,
	input  wire [47:0] load_data,
	input  wire [2:0]  rd_addr,
	output reg  [7:0]  rd_data,
	output wire [47:0] all_data
);
	reg [47:0] mem_reg;

	assign all_data = mem_reg;

	always @(posedge clk) begin
		if (load_en) begin
			mem_reg <= load_data;
		end else if (wr_en) begin
			mem_reg[wr_addr*8 +: 8] <= wr_data;
		end
		rd_data <= mem_reg[rd_addr*8 +: 8];
	end
endmodule
